// file: sdr_defs.vh
// Purpose: constants for the swap timing and dither register bank
// Assumes: register byte address is four times the register index
// Notes:   definitions only
`ifndef SDR_DEFS_VH
`define SDR_DEFS_VH

// register indexes, byte address = index * 4
`define SDR_IDX_OVERLAP      12'h09A
`define SDR_IDX_STEER        12'h09B
`define SDR_IDX_DITHER       12'h09D
`define SDR_IDX_STATUS       12'h09F
`define SDR_IDX_LOWBIT       12'h160

// reset values
`define SDR_RST_OVERLAP      5'h08
`define SDR_RST_STEER        5'h07
`define SDR_RST_DITHER       3'h0
`define SDR_RST_DITH_BIT     1'b0
`define SDR_RST_LOWBIT       8'h00

// field positions
`define SDR_DLY_MSB          4
`define SDR_DITH_EN_BIT      0
`define SDR_DITH_AMP_BIT     1
`define SDR_DITH_ERR_BIT     2
`define SDR_STAT_BUSY_BIT    0
`define SDR_STAT_OVL_BIT     1
`define SDR_STAT_CORE_BIT    2
`define SDR_STAT_STEER_BIT   3

// overlap length = base + scale * delay, in converter clock cycles
`define SDR_OVL_BASE         7'h04
`define SDR_OVL_SCALE        2

`endif

// file: sdr_regs.v
// Purpose: register bank for core swap timing and dither, with swap sequencer
// Assumes: hclk is the converter clock; swap_request comes from same-clock logic
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//
// What this block does
// - during a swap both cores sample together for 4 + 2 * overlap delay cycles
// - overlap delay is five bits, 0..31, reset 0x08
// - steering select delay is added to core select only during swaps
// - steering select delay is five bits, 0..31, reset 0x07
// - steering switch lands inside the window where both streams are valid only if steer delay < 3 + 2 * overlap delay
// - dither control bit 0 enables dither, reset cleared
// - dither control bit 1 picks small (0) or large (1) amplitude
// - dither control bit 2 picks where subtraction rounding error goes
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "sdr_defs.vh"

module sdr_regs (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        swap_request,
    output reg         swap_busy,
    output reg         both_cores_sample,
    output reg         active_core,
    output reg         steer_select,
    output reg         dither_enable,
    output reg         dither_amplitude,
    output reg         dither_rounding_select
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SWAP = 1'b1;

    reg  [4:0]  core_overlap_delay;
    reg  [4:0]  steer_select_delay;
    reg  [7:0]  low_bit_control;
    reg         dp_write;
    reg  [11:0] dp_index;
    reg         state;
    reg  [6:0]  swap_count;
    reg  [6:0]  ovl_len;
    reg  [4:0]  steer_len;
    wire        addr_phase;
    wire [11:0] addr_index;
    wire [6:0]  next_count;
    wire        ovl_done;
    wire        steer_done;

    // overlap window length for a given delay setting
    function [6:0] overlap_cycles;
        input [4:0] dly;
        begin
            // twice the delay is the delay shifted left once, kept at seven bits
            overlap_cycles = `SDR_OVL_BASE + {1'b0, dly, 1'b0};
        end
    endfunction

    function [31:0] read_mux;
        input [11:0] idx;
        begin
            case (idx)
                `SDR_IDX_OVERLAP: read_mux = {27'h0000000, core_overlap_delay};
                `SDR_IDX_STEER:   read_mux = {27'h0000000, steer_select_delay};
                `SDR_IDX_DITHER:  read_mux = {29'h0000000, dither_rounding_select,
                                              dither_amplitude, dither_enable};
                `SDR_IDX_STATUS:  read_mux = {28'h0000000, steer_select, active_core,
                                              both_cores_sample, swap_busy};
                `SDR_IDX_LOWBIT:  read_mux = {24'h000000, low_bit_control};
                default:          read_mux = 32'h00000000;
            endcase
        end
    endfunction

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel & htrans[1] & hready;
    assign addr_index = haddr[13:2];

    // bus side: address phase captured, write lands in data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_index <= 12'h000;
            hrdata   <= 32'h00000000;
        end else if (clk_en) begin
            dp_write <= addr_phase & hwrite;
            if (addr_phase) begin
                dp_index <= addr_index;
            end
            if (addr_phase & ~hwrite) begin
                hrdata <= read_mux(addr_index);
            end
        end
    end

    // reserved bits are dropped on write and read back as zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_overlap_delay     <= `SDR_RST_OVERLAP;
            steer_select_delay     <= `SDR_RST_STEER;
            dither_enable          <= `SDR_RST_DITH_BIT;
            dither_amplitude       <= `SDR_RST_DITH_BIT;
            dither_rounding_select <= `SDR_RST_DITH_BIT;
            low_bit_control        <= `SDR_RST_LOWBIT;
        end else if (clk_en && dp_write) begin
            case (dp_index)
                `SDR_IDX_OVERLAP: core_overlap_delay <= hwdata[`SDR_DLY_MSB:0];
                `SDR_IDX_STEER:   steer_select_delay <= hwdata[`SDR_DLY_MSB:0];
                `SDR_IDX_DITHER: begin
                    dither_enable          <= hwdata[`SDR_DITH_EN_BIT];
                    dither_amplitude       <= hwdata[`SDR_DITH_AMP_BIT];
                    dither_rounding_select <= hwdata[`SDR_DITH_ERR_BIT];
                end
                `SDR_IDX_LOWBIT:  low_bit_control <= hwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    assign next_count = swap_count + 7'h01;
    assign ovl_done   = (next_count >= ovl_len);
    assign steer_done = (next_count > {2'b00, steer_len});

    // swap sequencer: lengths latched at start so writes mid-swap wait
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state             <= ST_IDLE;
            swap_count        <= 7'h00;
            ovl_len           <= 7'h00;
            steer_len         <= 5'h00;
            swap_busy         <= 1'b0;
            both_cores_sample <= 1'b0;
            active_core       <= 1'b0;
            steer_select      <= 1'b0;
        end else if (clk_en) begin
            case (state)
                ST_IDLE: begin
                    steer_select <= active_core;
                    if (swap_request) begin
                        ovl_len           <= overlap_cycles(core_overlap_delay);
                        steer_len         <= steer_select_delay;
                        swap_count        <= 7'h00;
                        swap_busy         <= 1'b1;
                        both_cores_sample <= 1'b1;
                        active_core       <= ~active_core;
                        state             <= ST_SWAP;
                    end
                end
                ST_SWAP: begin
                    swap_count <= next_count;
                    if (ovl_done) begin
                        both_cores_sample <= 1'b0;
                    end
                    // mux follows the new core only after the programmed delay
                    if (swap_count == {2'b00, steer_len}) begin
                        steer_select <= active_core;
                    end
                    if (ovl_done && steer_done) begin
                        swap_busy <= 1'b0;
                        state     <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// file: sdr_regs_monitor.sv
// Purpose: assertions on the swap sequencer ports
// Assumes: clk_en high whenever a swap starts
// Notes:   bound to sdr_regs by port names
`timescale 1ns/1ps
module sdr_regs_monitor (
    input logic hclk,
    input logic hresetn,
    input logic clk_en,
    input logic swap_request,
    input logic swap_busy,
    input logic both_cores_sample,
    input logic active_core,
    input logic steer_select
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_start; swap_request && !swap_busy && clk_en; endsequence
    property p_start; s_start |=> swap_busy && both_cores_sample; endproperty
    a_start: assert property (p_start) else $error("swap did not start");
    property p_toggle; s_start |=> active_core != $past(active_core); endproperty
    a_toggle: assert property (p_toggle) else $error("core did not toggle");
    property p_min; $rose(both_cores_sample) |-> both_cores_sample [*4]; endproperty
    a_min: assert property (p_min) else $error("overlap too short");
    property p_fall; $fell(both_cores_sample) |-> $past(both_cores_sample, 4); endproperty
    a_fall: assert property (p_fall) else $error("overlap under four");
    property p_inbusy; both_cores_sample |-> swap_busy; endproperty
    a_inbusy: assert property (p_inbusy) else $error("overlap outside swap");
    property p_lag; $rose(swap_busy) |-> steer_select != active_core; endproperty
    a_lag: assert property (p_lag) else $error("steer did not lag");
    property p_idle; !swap_busy |-> steer_select == active_core; endproperty
    a_idle: assert property (p_idle) else $error("steer off when idle");
    property p_refuse; swap_busy && swap_request |=> $stable(active_core); endproperty
    a_refuse: assert property (p_refuse) else $error("swap restarted");
endmodule
bind sdr_regs sdr_regs_monitor u_sdr_regs_monitor (.*);

// file: sdr_tb.sv
// Purpose: self-checking bench for the swap timing and dither bank
// Assumes: zero wait-state slave, clk_en held high
// Notes:   run lengths are counted off the ports
`timescale 1ns/1ps
`include "sdr_defs.vh"
module testbench;
    logic        hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0, swap_request = 0;
    logic [31:0] haddr = 0, hwdata = 0, ovl_len = 0, lag_len = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    wire         hready, hreadyout, hresp, swap_busy, both_cores_sample, active_core;
    wire         steer_select, dither_enable, dither_amplitude, dither_rounding_select;
    wire  [31:0] hrdata;
    int          error_cnt = 0, check_count = 0;
    assign hready = hreadyout;
    sdr_regs u_sdr_regs (.*);
    always #10 hclk = ~hclk;
    // counts restart at the accepting edge so one driver owns them
    always @(posedge hclk) begin
        ovl_len <= (swap_request && !swap_busy) ? 0 : ovl_len + both_cores_sample;
        lag_len <= (swap_request && !swap_busy) ? 0 :
                   lag_len + (swap_busy && steer_select != active_core);
    end
    task final_report;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {18'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rw(input logic [11:0] idx, input logic [31:0] wd, input logic [31:0] exp);
        logic [31:0] rd;
        if (wd !== 32'hFFFF_FFFF)
            bus(1, idx, wd, rd);
        bus(0, idx, 0, rd);
        chk(rd, exp);
        chk(hresp, 0);
    endtask
    task automatic t_dither;
        for (int i = 0; i < 9; i++) begin
            rw(`SDR_IDX_DITHER, i & 7, i & 7);
            chk({dither_rounding_select, dither_amplitude, dither_enable}, i & 7);
        end
    endtask
    task automatic t_swap(input logic [4:0] d, input logic [4:0] s, input logic [4:0] d_new);
        logic [31:0] rd;
        bus(1, `SDR_IDX_OVERLAP, d, rd);
        bus(1, `SDR_IDX_STEER, s, rd);
        swap_request <= 1;
        @(posedge hclk);
        swap_request <= 0;
        // a write landing mid-swap must leave this swap alone
        bus(1, `SDR_IDX_OVERLAP, d_new, rd);
        for (int n = 0; n < 200 && swap_busy !== 1'b0; n++) @(posedge hclk);
        chk(ovl_len, 4 + 2 * d);
        chk(lag_len, s + 1);
    endtask
    // ten thousand cycles, far beyond the few hundred the run needs
    initial begin
        #200000;
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        rw(`SDR_IDX_OVERLAP, 32'hFFFF_FFFF, 32'h8);
        rw(`SDR_IDX_STEER, 32'hFFFF_FFFF, 32'h7);
        rw(`SDR_IDX_DITHER, 32'hFFFF_FFFF, 32'h0);
        rw(`SDR_IDX_LOWBIT, 32'hFFFF_FFFF, 32'h0);
        rw(12'h09C, 32'h0, 32'h0);
        rw(`SDR_IDX_OVERLAP, 32'h1F, 32'h1F);
        rw(`SDR_IDX_STEER, 32'h1F, 32'h1F);
        t_dither;
        t_swap(0, 0, 5);
        rw(`SDR_IDX_STATUS, 32'hFFFF_FFFF, 32'hC);
        t_swap(31, 31, 0);
        t_swap(7, 3, 1);
        final_report;
    end
endmodule
